// ===== fex_pipe_model.sv
/*
 issue pipeline model: hands one instruction at a time to the exception unit.
 assumes it shares pclk with the unit; send returns just after the result edge.
*/
`timescale 1ns/1ps
`default_nettype none
module fex_pipe_model
   import fex_pkg::*;
(
   input wire logic pclk,
   output logic issue_valid,
   output fex_op_t issue_op,
   output logic issue_sw_compl,
   output logic [4:0] issue_trap_en,
   output logic [63:0] opnd_a,
   output logic [63:0] opnd_b,
   output logic [63:0] dp_result,
   output logic dp_ovf,
   output logic dp_unf,
   output logic dp_inex
);
   initial
   begin
      issue_valid = 1'b0;
      issue_op = FEX_OP_ADD;
      {issue_sw_compl, issue_trap_en, opnd_a, opnd_b, dp_result, dp_ovf, dp_unf, dp_inex} = '0;
   end

   task send(input fex_op_t op, input logic sc, input logic [4:0] te, input logic [63:0] a,
             input logic [63:0] b, input logic [63:0] d, input logic [2:0] f);
      @(posedge pclk);
      issue_valid <= 1'b1;
      issue_op <= op;
      {issue_sw_compl, issue_trap_en, opnd_a, opnd_b, dp_result} <= {sc, te, a, b, d};
      {dp_ovf, dp_unf, dp_inex} <= f;
      @(posedge pclk);
      issue_valid <= 1'b0;
      // stale operands are inverted so nothing can lean on a held value
      opnd_a <= ~a;
      opnd_b <= ~b;
      dp_result <= ~d;
      #1;
   endtask
endmodule
`default_nettype wire

// ===== fex_pkg.sv
/*
 floating-point exception unit package: register offsets, control word layout,
 exception indices, encodings and the state record.
 assumes 64-bit register-format operands (single precision held widened).
*/
package fex_pkg;

   localparam logic [11:0] FEX_OFF_CTRL = 12'h000;
   localparam logic [11:0] FEX_OFF_EXCEPTION_SUMMARY_REG = 12'h004;
   localparam logic [11:0] FEX_OFF_IRQ_STAT = 12'h008;
   localparam logic [11:0] FEX_OFF_IRQ_MASK = 12'h00C;
   localparam logic [11:0] FEX_OFF_ARCH_MASK_QUERY = 12'h010;

   // exception index within five-bit vectors
   localparam int FEX_X_INEX = 0;
   localparam int FEX_X_UNF = 1;
   localparam int FEX_X_OVF = 2;
   localparam int FEX_X_DZ = 3;
   localparam int FEX_X_INV = 4;
   // sixth bit of summary and interrupt vectors: denormal input trap
   localparam int FEX_X_DEN = 5;

   // control word field positions
   localparam int FEX_CW_STATUS_LO = 0;
   localparam int FEX_CW_DIS_LO = 8;
   localparam int FEX_CW_UNDERFLOW_FLUSH_ZERO = 13;
   localparam int FEX_CW_DNZ = 14;

   // operand class bits returned by the classifier
   localparam int FEX_C_ZERO = 0;
   localparam int FEX_C_DEN = 1;
   localparam int FEX_C_SNAN = 2;
   localparam int FEX_C_NAN = 3;
   localparam int FEX_C_INF = 4;

   localparam logic [63:0] FEX_CANON_QNAN = 64'h7FF8_0000_0000_0000;
   localparam logic [63:0] FEX_QUIET_BIT = 64'h0008_0000_0000_0000;
   localparam logic [62:0] FEX_INF_MAG = 63'h7FF0_0000_0000_0000;
   localparam logic [63:0] FEX_POS_ZERO = 64'h0000_0000_0000_0000;
   localparam logic [31:0] FEX_ARCH_MASK_QUERY_RESULT = 32'h0000_0200;
   localparam int FEX_ARCH_MASK_QUERY_PRECISE = 9;

   typedef enum logic [3:0] {
      FEX_OP_ADD, FEX_OP_SUB, FEX_OP_MUL, FEX_OP_DIV,
      FEX_OP_SQRT_S, FEX_OP_SQRT_T, FEX_OP_SQRT_F, FEX_OP_SQRT_G,
      FEX_OP_CMP, FEX_OP_COPY_SIGN_EXPONENT, FEX_OP_COPY_SIGN_NEGATE, FEX_OP_FCMOV,
      FEX_OP_MTFC, FEX_OP_MFFC, FEX_OP_TRAP_BARRIER_INSTR, FEX_OP_ARCH_MASK_QUERY
   } fex_op_t;

   typedef struct packed {
      logic denormal_to_zero_enable;
      logic underflow_flush_zero;
      logic [4:0] dis;
      logic [4:0] status;
   } fex_ctrl_t;

   typedef struct packed {
      fex_ctrl_t ctrl;
      logic [5:0] exception_summary_reg;
      logic [5:0] irq_stat;
      logic [5:0] irq_mask;
      logic [63:0] res;
      logic res_valid;
      logic [4:0] res_exc;
      logic trap;
      logic [5:0] trap_cause;
      logic irq;
      logic [31:0] prdata;
      logic pready;
      logic pslverr;
   } fex_state_t;

endpackage

// ===== fex_unit.sv
/*
 floating-point exception unit: operand screening, nan handling, trap decision,
 result substitution, sticky status, trap summary, interrupt and apb slave.
 assumes the arithmetic datapath delivers its raw result and result flags in
 the issue cycle; all inputs are synchronous to pclk.
*/
`timescale 1ns/1ps
`default_nettype none

// Function
// - precise traps, mask query bit, barrier ignored
// - propagate nans, signalling nan raises invalid
// - fresh nan result is canonical quiet nan
// - infinity minus infinity gives canonical invalid
// - square root accepted in four formats
// - denormal input traps unless flush and completion
// - denormal trap without flush ignores disables
// - copies, moves pass denormals without trap
// - five trap disable bits in control
// - disabled completion exception writes nontrapping result
// - underflow writes positive zero, flags underflow
// - status bits set always and accumulate
// - status cleared only by explicit control write
// - enabled undisabled exception records summary, traps
// - input operand trap beats result trap
module fex_unit
   import fex_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic issue_valid,
   input wire fex_op_t issue_op,
   input wire logic issue_sw_compl,
   input wire logic [4:0] issue_trap_en,
   input wire logic [63:0] opnd_a,
   input wire logic [63:0] opnd_b,
   input wire logic [63:0] dp_result,
   input wire logic dp_ovf,
   input wire logic dp_unf,
   input wire logic dp_inex,
   output logic [63:0] res_q,
   output logic res_valid_q,
   output logic [4:0] res_exc_q,
   output logic trap_q,
   output logic [5:0] trap_cause_q,
   output logic irq_q
);

   fex_state_t s_q;
   fex_state_t s_d;

   logic [4:0] ca;
   logic [4:0] cb;
   logic arith;
   logic is_sqrt;
   logic den_in;
   logic den_trap;
   logic snan_in;
   logic nan_in;
   logic inv_cq;
   logic dz_in;
   logic input_special;
   logic [4:0] exc;
   logic [4:0] exc_det;
   logic [4:0] trapped;
   logic res_trap;
   logic [63:0] arith_res;
   logic apb_setup;
   logic apb_access;
   logic ctrl_wr;
   logic mapped;

   function automatic logic [4:0] classify(input logic [63:0] v);
      logic emax;
      logic emin;
      logic fnz;
      emax = &v[62:52];
      emin = ~|v[62:52];
      fnz = |v[51:0];
      classify = {emax & ~fnz, emax & fnz, emax & fnz & ~v[51], emin & fnz, emin & ~fnz};
   endfunction

   function automatic logic [31:0] ctrl_pack(input fex_ctrl_t c);
      ctrl_pack = 32'h0000_0000;
      ctrl_pack[FEX_CW_STATUS_LO +: 5] = c.status;
      ctrl_pack[FEX_CW_DIS_LO +: 5] = c.dis;
      ctrl_pack[FEX_CW_UNDERFLOW_FLUSH_ZERO] = c.underflow_flush_zero;
      ctrl_pack[FEX_CW_DNZ] = c.denormal_to_zero_enable;
   endfunction

   function automatic fex_ctrl_t ctrl_unpack(input logic [31:0] w);
      ctrl_unpack.status = w[FEX_CW_STATUS_LO +: 5];
      ctrl_unpack.dis = w[FEX_CW_DIS_LO +: 5];
      ctrl_unpack.underflow_flush_zero = w[FEX_CW_UNDERFLOW_FLUSH_ZERO];
      ctrl_unpack.denormal_to_zero_enable = w[FEX_CW_DNZ];
   endfunction

   // operand screening
   always_comb
   begin
      ca = classify(opnd_a);
      cb = classify(opnd_b);
      is_sqrt = (issue_op == FEX_OP_SQRT_S) || (issue_op == FEX_OP_SQRT_T) ||
                (issue_op == FEX_OP_SQRT_F) || (issue_op == FEX_OP_SQRT_G);
      // copies, conditional moves and control moves are not arithmetic
      arith = (issue_op == FEX_OP_ADD) || (issue_op == FEX_OP_SUB) || (issue_op == FEX_OP_MUL) ||
              (issue_op == FEX_OP_DIV) || (issue_op == FEX_OP_CMP) || is_sqrt;
      den_in = ca[FEX_C_DEN] | (~is_sqrt & cb[FEX_C_DEN]);
      // no disable bit enters this term, so it cannot be masked
      den_trap = issue_valid & arith & den_in & ~(s_q.ctrl.denormal_to_zero_enable & issue_sw_compl);
      snan_in = ca[FEX_C_SNAN] | (~is_sqrt & cb[FEX_C_SNAN]);
      nan_in = ca[FEX_C_NAN] | (~is_sqrt & cb[FEX_C_NAN]);
      inv_cq = 1'b0;
      if (!nan_in)
      begin
         unique case (issue_op)
            FEX_OP_ADD: inv_cq = ca[FEX_C_INF] & cb[FEX_C_INF] & (opnd_a[63] ^ opnd_b[63]);
            FEX_OP_SUB: inv_cq = ca[FEX_C_INF] & cb[FEX_C_INF] & ~(opnd_a[63] ^ opnd_b[63]);
            FEX_OP_MUL: inv_cq = (ca[FEX_C_INF] & cb[FEX_C_ZERO]) | (ca[FEX_C_ZERO] & cb[FEX_C_INF]);
            FEX_OP_DIV: inv_cq = (ca[FEX_C_ZERO] & cb[FEX_C_ZERO]) | (ca[FEX_C_INF] & cb[FEX_C_INF]);
            FEX_OP_SQRT_S, FEX_OP_SQRT_T, FEX_OP_SQRT_F, FEX_OP_SQRT_G:
               inv_cq = opnd_a[63] & ~ca[FEX_C_ZERO];
            FEX_OP_CMP, FEX_OP_COPY_SIGN_EXPONENT, FEX_OP_COPY_SIGN_NEGATE, FEX_OP_FCMOV,
            FEX_OP_MTFC, FEX_OP_MFFC, FEX_OP_TRAP_BARRIER_INSTR, FEX_OP_ARCH_MASK_QUERY: inv_cq = 1'b0;
         endcase
      end
      dz_in = (issue_op == FEX_OP_DIV) & cb[FEX_C_ZERO] & ~ca[FEX_C_ZERO] & ~nan_in & ~ca[FEX_C_INF];
      input_special = nan_in | inv_cq | dz_in;
      exc = 5'h00;
      exc[FEX_X_INV] = snan_in | inv_cq;
      exc[FEX_X_DZ] = dz_in;
      if (!input_special && issue_op != FEX_OP_CMP)
      begin
         // all result flags land together
         exc[FEX_X_OVF] = dp_ovf;
         exc[FEX_X_UNF] = dp_unf;
         exc[FEX_X_INEX] = dp_inex;
      end
      // a denormal trap means no result was formed, so no result exception exists
      exc_det = (issue_valid & arith & ~den_trap) ? exc : 5'h00;
      trapped = exc_det & issue_trap_en & ~(s_q.ctrl.dis & {5{issue_sw_compl}});
      res_trap = |trapped;
      if (inv_cq)
         arith_res = FEX_CANON_QNAN;
      else if (nan_in)
         arith_res = (ca[FEX_C_NAN] ? opnd_a : opnd_b) | FEX_QUIET_BIT;
      else if (dz_in)
         arith_res = {opnd_a[63] ^ opnd_b[63], FEX_INF_MAG};
      else if (exc[FEX_X_UNF])
         arith_res = FEX_POS_ZERO;
      else if (exc[FEX_X_OVF] && s_q.ctrl.dis[FEX_X_OVF] && issue_sw_compl)
         arith_res = {dp_result[63], FEX_INF_MAG};
      else
         arith_res = dp_result;
   end

   // apb decode
   always_comb
   begin
      apb_setup = psel & ~penable;
      apb_access = psel & penable & s_q.pready;
      mapped = (paddr == FEX_OFF_CTRL) || (paddr == FEX_OFF_EXCEPTION_SUMMARY_REG) || (paddr == FEX_OFF_IRQ_STAT) ||
               (paddr == FEX_OFF_IRQ_MASK) || (paddr == FEX_OFF_ARCH_MASK_QUERY);
      ctrl_wr = (apb_access & pwrite & (paddr == FEX_OFF_CTRL)) | (issue_valid & (issue_op == FEX_OP_MTFC));
   end

   always_comb
   begin
      s_d = s_q;
      s_d.res_valid = 1'b0;
      s_d.trap = 1'b0;
      s_d.pready = 1'b0;
      s_d.pslverr = 1'b0;
      if (issue_valid)
      begin
         s_d.res_exc = exc_det;
         unique case (issue_op)
            FEX_OP_COPY_SIGN_EXPONENT: s_d.res = {opnd_a[63:52], opnd_b[51:0]};
            FEX_OP_COPY_SIGN_NEGATE: s_d.res = {~opnd_a[63], opnd_b[62:0]};
            FEX_OP_FCMOV: s_d.res = opnd_b;
            FEX_OP_MFFC: s_d.res = {32'h0000_0000, ctrl_pack(s_q.ctrl)};
            FEX_OP_ARCH_MASK_QUERY: s_d.res = {32'h0000_0000, FEX_ARCH_MASK_QUERY_RESULT};
            FEX_OP_MTFC, FEX_OP_TRAP_BARRIER_INSTR: s_d.res = s_q.res;
            FEX_OP_ADD, FEX_OP_SUB, FEX_OP_MUL, FEX_OP_DIV, FEX_OP_CMP,
            FEX_OP_SQRT_S, FEX_OP_SQRT_T, FEX_OP_SQRT_F, FEX_OP_SQRT_G: s_d.res = arith_res;
         endcase
         // the barrier writes no result or exception: precise traps make it a no-op
         s_d.res_valid = (issue_op != FEX_OP_TRAP_BARRIER_INSTR) && (issue_op != FEX_OP_MTFC) &&
                         !den_trap && !res_trap;
         if (issue_op == FEX_OP_TRAP_BARRIER_INSTR)
            s_d.res_exc = 5'h00;
         if (den_trap)
         begin
            s_d.trap = 1'b1;
            s_d.trap_cause = 6'h20;
            s_d.exception_summary_reg = 6'h20;
         end
         else if (res_trap)
         begin
            s_d.trap = 1'b1;
            s_d.trap_cause = {1'b0, trapped};
            s_d.exception_summary_reg = {1'b0, trapped};
         end
         if (issue_op == FEX_OP_MTFC)
            s_d.ctrl = ctrl_unpack(opnd_a[31:0]);
      end
      if (apb_setup)
      begin
         s_d.pready = 1'b1;
         s_d.pslverr = !mapped;
         s_d.prdata = 32'h0000_0000;
         if (!pwrite)
         begin
            if (paddr == FEX_OFF_CTRL)
               s_d.prdata = ctrl_pack(s_q.ctrl);
            else if (paddr == FEX_OFF_EXCEPTION_SUMMARY_REG)
               s_d.prdata = {26'h000_0000, s_q.exception_summary_reg};
            else if (paddr == FEX_OFF_IRQ_STAT)
               s_d.prdata = {26'h000_0000, s_q.irq_stat};
            else if (paddr == FEX_OFF_IRQ_MASK)
               s_d.prdata = {26'h000_0000, s_q.irq_mask};
            else if (paddr == FEX_OFF_ARCH_MASK_QUERY)
               s_d.prdata = FEX_ARCH_MASK_QUERY_RESULT;
         end
      end
      if (apb_access && pwrite && pstrb[0] && pstrb[1])
      begin
         // bus write applies after a move in the same cycle
         if (paddr == FEX_OFF_CTRL)
            s_d.ctrl = ctrl_unpack(pwdata);
         else if (paddr == FEX_OFF_IRQ_MASK)
            s_d.irq_mask = pwdata[5:0];
      end
      if (apb_access && !pwrite && paddr == FEX_OFF_IRQ_STAT)
         s_d.irq_stat = 6'h00;
      // set wins over any clear in the same cycle
      s_d.ctrl.status = s_d.ctrl.status | exc_det;
      s_d.irq_stat = s_d.irq_stat | {den_trap, exc_det};
      s_d.irq = |(s_d.irq_stat & s_d.irq_mask);
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         s_q <= '0;
      else
         s_q <= s_d;
   end

   assign prdata = s_q.prdata;
   assign pready = s_q.pready;
   assign pslverr = s_q.pslverr;
   assign res_q = s_q.res;
   assign res_valid_q = s_q.res_valid;
   assign res_exc_q = s_q.res_exc;
   assign trap_q = s_q.trap;
   assign trap_cause_q = s_q.trap_cause;
   assign irq_q = s_q.irq;

   AST_DENORM_UNMASKABLE: assert property (@(posedge pclk) disable iff (!presetn)
      (issue_valid && arith && den_in && !s_q.ctrl.denormal_to_zero_enable) |=> (trap_q && trap_cause_q == 6'h20 && !res_valid_q))
      else $error("denormal input without flush did not trap");

   AST_DENORM_AVOID: assert property (@(posedge pclk) disable iff (!presetn)
      (issue_valid && arith && den_in && s_q.ctrl.denormal_to_zero_enable && issue_sw_compl) |=> !trap_cause_q[FEX_X_DEN] || !trap_q)
      else $error("denormal trap taken despite flush and completion");

   AST_NONARITH_PASS: assert property (@(posedge pclk) disable iff (!presetn)
      (issue_valid && (issue_op == FEX_OP_FCMOV)) |=> (!trap_q && res_valid_q && res_q == $past(opnd_b)))
      else $error("conditional move altered value or trapped");

   AST_INF_SUB: assert property (@(posedge pclk) disable iff (!presetn)
      (issue_valid && issue_op == FEX_OP_SUB && ca[FEX_C_INF] && cb[FEX_C_INF] && opnd_a[63] == opnd_b[63] &&
       !den_trap) |=> (res_q == FEX_CANON_QNAN && res_exc_q[FEX_X_INV]))
      else $error("infinity difference not canonical invalid");

   AST_SNAN_QUIET: assert property (@(posedge pclk) disable iff (!presetn)
      (issue_valid && arith && snan_in && !den_trap && issue_op != FEX_OP_CMP) |=>
      (res_exc_q[FEX_X_INV] && res_q[51]))
      else $error("signalling nan not quieted with invalid");

   AST_UNF_ZERO: assert property (@(posedge pclk) disable iff (!presetn)
      (res_valid_q && res_exc_q[FEX_X_UNF]) |-> (res_q == FEX_POS_ZERO))
      else $error("underflow result not positive zero");

   AST_STATUS_STICKY: assert property (@(posedge pclk) disable iff (!presetn)
      (s_q.ctrl.status != ($past(s_q.ctrl.status) | $past(exc_det))) |-> $past(ctrl_wr))
      else $error("status changed without explicit control write");

   AST_STATUS_SET: assert property (@(posedge pclk) disable iff (!presetn)
      (issue_valid && arith && !den_trap && issue_op != FEX_OP_CMP && dp_ovf && dp_inex && !input_special) |=>
      (s_q.ctrl.status[FEX_X_OVF] && s_q.ctrl.status[FEX_X_INEX]))
      else $error("detected exceptions not all recorded");

   AST_SUPPRESS: assert property (@(posedge pclk) disable iff (!presetn)
      (issue_valid && !den_trap && issue_sw_compl && ((exc_det & ~s_q.ctrl.dis) == 5'h00) && exc_det != 5'h00)
      |=> (!trap_q && res_valid_q))
      else $error("disabled exception still trapped");

   AST_TRAP_SUMMARY: assert property (@(posedge pclk) disable iff (!presetn)
      trap_q |-> (s_q.exception_summary_reg == trap_cause_q && trap_cause_q != 6'h00))
      else $error("trap without matching summary");

   AST_BARRIER_NOP: assert property (@(posedge pclk) disable iff (!presetn)
      (issue_valid && issue_op == FEX_OP_TRAP_BARRIER_INSTR) |=> (!res_valid_q && !trap_q))
      else $error("barrier produced activity");

   AST_ARCH_MASK_QUERY_BIT: assert property (@(posedge pclk) disable iff (!presetn)
      (issue_valid && issue_op == FEX_OP_ARCH_MASK_QUERY) |=> (res_valid_q && res_q[FEX_ARCH_MASK_QUERY_PRECISE]))
      else $error("mask query missing precise bit");

endmodule

`default_nettype wire

// ===== fex_unit_tb.sv
/*
 self-checking bench for the exception unit: apb register tasks, issue via the
 pipeline model, expected results from the package encodings.
 assumes zero-wait apb answers are waited for, not counted.
*/
`timescale 1ns/1ps
`default_nettype none
module fex_unit_tb
   import fex_pkg::*;
;
   localparam logic [63:0] SNAN = 64'h7FF0_0000_0000_0001;
   localparam logic [63:0] INF = 64'h7FF0_0000_0000_0000;
   localparam logic [63:0] NEG4 = 64'hC010_0000_0000_0000;
   localparam logic [63:0] ONE = 64'h3FF0_0000_0000_0000;
   localparam logic [63:0] DEN = 64'h0000_0000_0000_0001;
   localparam logic [63:0] BIG = 64'h7FEF_FFFF_FFFF_FFFF;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [3:0] pstrb;
   logic issue_valid, issue_sw_compl, dp_ovf, dp_unf, dp_inex;
   fex_op_t issue_op;
   logic [4:0] issue_trap_en, res_exc_q;
   logic [63:0] opnd_a, opnd_b, dp_result, res_q;
   logic res_valid_q, trap_q, irq_q;
   logic [5:0] trap_cause_q;
   int failures = 0;
   int comparisons = 0;
   fex_op_t sq[4] = '{FEX_OP_SQRT_S, FEX_OP_SQRT_T, FEX_OP_SQRT_F, FEX_OP_SQRT_G};
   fex_op_t cp[3] = '{FEX_OP_COPY_SIGN_EXPONENT, FEX_OP_COPY_SIGN_NEGATE, FEX_OP_FCMOV};
   logic [63:0] cx[3] = '{64'hC010_0000_0000_0001, DEN, DEN};

   fex_unit dut_u (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata,
      .pready, .pslverr, .issue_valid, .issue_op, .issue_sw_compl, .issue_trap_en, .opnd_a,
      .opnd_b, .dp_result, .dp_ovf, .dp_unf, .dp_inex, .res_q, .res_valid_q, .res_exc_q,
      .trap_q, .trap_cause_q, .irq_q);
   fex_pipe_model pm (.pclk, .issue_valid, .issue_op, .issue_sw_compl, .issue_trap_en,
      .opnd_a, .opnd_b, .dp_result, .dp_ovf, .dp_unf, .dp_inex);

   always #5 pclk = ~pclk;

   task end_of_test;
      $display("comparisons %0d failures %0d", comparisons, failures);
      if (failures == 0 && comparisons > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask

   task chk(input logic [63:0] s, input logic [63:0] e);
      comparisons++;
      if (s !== e)
      begin
         failures++;
         $display("BAD t=%0t seen %h expected %h", $time, s, e);
      end
   endtask

   task ob(input logic v, input logic t, input logic [63:0] r, input logic [5:0] x);
      chk(res_valid_q, v);
      chk(trap_q, t);
      if (v)
      begin
         chk(res_q, r);
         chk(res_exc_q, x[4:0]);
      end
      if (t)
         chk(trap_cause_q, x);
   endtask

   // holds the request until pready is seen at a rising edge
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1)
         @(posedge pclk);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task tick;
      @(posedge pclk);
      #1;
   endtask

   initial
   begin
      repeat (20000) @(posedge pclk);
      failures++;
      end_of_test;
   end

   initial
   begin
      {pclk, presetn, psel, penable, pwrite, paddr, pwdata} = '0;
      pstrb = 4'hF;
      repeat (5) @(posedge pclk);
      presetn <= 1'b1;
      apb(0, FEX_OFF_CTRL, 0);
      chk(rd, 0);
      apb(0, FEX_OFF_ARCH_MASK_QUERY, 0);
      chk(rd, 32'h0000_0200);
      apb(0, 12'h020, 0);
      chk({err, rd}, 33'h1_0000_0000);
      $display("registers done");
      pm.send(FEX_OP_ADD, 0, 0, SNAN, ONE, ONE, 0);
      ob(1, 0, 64'h7FF8_0000_0000_0001, 6'h10);
      pm.send(FEX_OP_SUB, 0, 0, INF, INF, ONE, 0);
      ob(1, 0, FEX_CANON_QNAN, 6'h10);
      foreach (sq[i])
      begin
         pm.send(sq[i], 0, 0, NEG4, 0, ONE, 0);
         ob(1, 0, FEX_CANON_QNAN, 6'h10);
      end
      pm.send(FEX_OP_MUL, 0, 0, ONE, ONE, BIG, 3'b101);
      ob(1, 0, BIG, 6'h05);
      apb(0, FEX_OFF_CTRL, 0);
      chk(rd, 32'h15);
      apb(1, FEX_OFF_CTRL, 0);
      apb(0, FEX_OFF_CTRL, 0);
      chk(rd, 0);
      pm.send(FEX_OP_MUL, 0, 0, ONE, ONE, 64'h5, 3'b010);
      ob(1, 0, 0, 6'h02);
      $display("nan and status done");
      // underflow disable always goes with the flush bit
      apb(1, FEX_OFF_CTRL, 32'h3F00);
      apb(0, FEX_OFF_CTRL, 0);
      chk(rd, 32'h3F00);
      pm.send(FEX_OP_MUL, 1, 5'h04, ONE, ONE, BIG, 3'b100);
      ob(1, 0, INF, 6'h04);
      pm.send(FEX_OP_ADD, 1, 5'h10, SNAN, ONE, ONE, 0);
      ob(1, 0, 64'h7FF8_0000_0000_0001, 6'h10);
      pm.send(FEX_OP_MUL, 0, 5'h04, ONE, ONE, BIG, 3'b100);
      ob(0, 1, 0, 6'h04);
      apb(0, FEX_OFF_EXCEPTION_SUMMARY_REG, 0);
      chk(rd, 32'h04);
      $display("disables done");
      pm.send(FEX_OP_ADD, 1, 5'h04, DEN, ONE, BIG, 3'b100);
      ob(0, 1, 0, 6'h20);
      chk(irq_q, 0);
      apb(1, FEX_OFF_IRQ_MASK, 32'h20);
      tick;
      chk(irq_q, 1);
      apb(0, FEX_OFF_IRQ_STAT, 0);
      chk(rd[5], 1);
      tick;
      chk(irq_q, 0);
      apb(1, FEX_OFF_CTRL, 32'h4000);
      pm.send(FEX_OP_ADD, 1, 0, DEN, ONE, ONE, 0);
      ob(1, 0, ONE, 0);
      // an enabled, undisabled overflow rides along, so precedence is really exercised
      pm.send(FEX_OP_ADD, 0, 5'h04, DEN, ONE, BIG, 3'b100);
      ob(0, 1, 0, 6'h20);
      apb(1, FEX_OFF_CTRL, 0);
      foreach (cp[i])
      begin
         pm.send(cp[i], 0, 5'h1F, NEG4, DEN, ONE, 0);
         ob(1, 0, cx[i], 0);
      end
      pm.send(FEX_OP_TRAP_BARRIER_INSTR, 0, 5'h1F, ONE, ONE, ONE, 0);
      ob(0, 0, 0, 0);
      pm.send(FEX_OP_ARCH_MASK_QUERY, 0, 0, ONE, ONE, ONE, 0);
      ob(1, 0, 64'h0000_0000_0000_0200, 0);
      pm.send(FEX_OP_DIV, 0, 0, NEG4, 0, ONE, 0);
      ob(1, 0, 64'hFFF0_0000_0000_0000, 6'h08);
      pm.send(FEX_OP_MFFC, 0, 0, ONE, ONE, ONE, 0);
      ob(1, 0, 64'h0000_0000_0000_0008, 0);
      pm.send(FEX_OP_MTFC, 0, 0, 64'h0000_0000_0000_4000, ONE, ONE, 0);
      ob(0, 0, 0, 0);
      pm.send(FEX_OP_MFFC, 0, 0, ONE, ONE, ONE, 0);
      ob(1, 0, 64'h0000_0000_0000_4000, 0);
      $display("denormal done");
      end_of_test;
   end
endmodule
`default_nettype wire
